/* core/sst_pkg.sv */
// constants, opcodes and register map for the subtract, swap and table read slice
// assumes a 200 MHz hclk and a single AHB-Lite master
package sst_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned ROM_W = 14;
    localparam int unsigned ROM_AW = 11;
    localparam int unsigned FREG_AW = 6;
    localparam int unsigned TPH_W = 3;
    localparam int unsigned TDH_W = 6;
    localparam int unsigned FLAG_W = 3;

    // register offsets, byte addresses
    localparam logic [7:0] OFS_ACC = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h04;
    localparam logic [7:0] OFS_TPH = 8'h08;
    localparam logic [7:0] OFS_TDH = 8'h0c;
    localparam logic [7:0] OFS_STATE = 8'h10;

    // flag field positions
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_DC = 1;
    localparam int unsigned FLAG_Z = 2;

    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [2:0] FLAGS_RST = 3'h0;
    localparam logic [2:0] TPH_RST = 3'h0;
    localparam logic [5:0] TDH_RST = 6'h00;

    // instruction cycles
    localparam int unsigned SINGLE_CYCLES = 1;
    localparam int unsigned TABLE_CYCLES = 2;

    typedef enum logic [1:0] {
        SST_OP_SUB_REG = 2'b00,
        SST_OP_SUB_IMM = 2'b01,
        SST_OP_SWAP = 2'b10,
        SST_OP_TABLE = 2'b11
    } sst_op_t;

    typedef enum logic {
        SST_ST_RUN = 1'b0,
        SST_ST_TABLE = 1'b1
    } sst_state_t;

endpackage

/* core/sst_sub8.sv */
// eight bit subtractor with zero, half-carry and carry flags
// assumes carry means no borrow, as on two's complement subtract
`timescale 1ns/1ps
module sst_sub8
    import sst_pkg::*;
(
    input wire logic [7:0] minuend,
    input wire logic [7:0] subtrahend,
    output logic [7:0] result,
    output logic flag_z,
    output logic flag_dc,
    output logic flag_c
);

    logic [8:0] full_sum;
    logic [4:0] low_sum;

    // minuend plus inverted subtrahend plus one
    assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
    assign low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
    assign result = full_sum[7:0];
    assign flag_z = (full_sum[7:0] == 8'h00);
    assign flag_dc = low_sum[4];
    assign flag_c = full_sum[8];

endmodule

/* core/sst_exec.sv */
// execution slice: two subtracts, nibble swap and rom table read, plus an AHB-Lite register slave
// assumes decoder, file registers and program rom answer within the same cycle
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module sst_exec
    import sst_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic instr_valid,
    input wire logic [1:0] instr_op,
    input wire logic [5:0] instr_reg_addr,
    input wire logic instr_dest,
    input wire logic [7:0] instr_imm,
    input wire logic [7:0] freg_rdata,
    output logic instr_stall,
    output logic freg_we,
    output logic [5:0] freg_waddr,
    output logic [7:0] freg_wdata,
    output logic rom_rd,
    output logic [10:0] rom_addr,
    input wire logic [13:0] rom_data,
    output logic [7:0] acc,
    output logic [2:0] flags
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    sst_state_t state;
    sst_state_t next_state;
    logic [2:0] table_pointer_high;
    logic [5:0] table_data_high;
    logic [7:0] next_acc;
    logic [2:0] next_flags;
    logic [2:0] next_table_pointer_high;
    logic [5:0] next_table_data_high;
    logic next_instr_stall;
    logic next_freg_we;
    logic [5:0] next_freg_waddr;
    logic [7:0] next_freg_wdata;
    logic next_rom_rd;
    logic [10:0] next_rom_addr;

    logic wr_pend;
    logic [7:0] wr_addr;
    logic next_wr_pend;
    logic [7:0] next_wr_addr;
    logic [31:0] next_hrdata;

    sst_op_t op;
    logic take;
    logic [7:0] sub_minuend;
    logic [7:0] sub_result;
    logic sub_z;
    logic sub_dc;
    logic sub_c;
    logic [7:0] swap_result;
    logic addr_phase;

    assign op = sst_op_t'(instr_op);
    assign take = instr_valid && !instr_stall && (state == SST_ST_RUN);
    assign addr_phase = hsel && hready && htrans[1];

    ////////////////////////////////////////////////////////////////////////////////
    // datapath

    // immediate or file register as minuend
    assign sub_minuend = (op == SST_OP_SUB_IMM) ? instr_imm : freg_rdata;

    sst_sub8 u_sub (
        .minuend(sub_minuend),
        .subtrahend(acc),
        .result(sub_result),
        .flag_z(sub_z),
        .flag_dc(sub_dc),
        .flag_c(sub_c)
    );

    assign swap_result = {freg_rdata[3:0], freg_rdata[7:4]};

    ////////////////////////////////////////////////////////////////////////////////
    // execution next values

    always_comb begin
        next_state = state;
        next_acc = acc;
        next_flags = flags;
        next_table_pointer_high = table_pointer_high;
        next_table_data_high = table_data_high;
        next_instr_stall = 1'b0;
        next_freg_we = 1'b0;
        next_freg_waddr = freg_waddr;
        next_freg_wdata = freg_wdata;
        next_rom_rd = 1'b0;
        next_rom_addr = rom_addr;
        // bus writes first, instruction results override them
        if (wr_pend) begin
            if (wr_addr == OFS_ACC) begin
                next_acc = hwdata[7:0];
            end else if (wr_addr == OFS_FLAGS) begin
                next_flags = hwdata[2:0];
            end else if (wr_addr == OFS_TPH) begin
                next_table_pointer_high = hwdata[2:0];
            end else if (wr_addr == OFS_TDH) begin
                next_table_data_high = hwdata[5:0];
            end
        end
        case (state)
            SST_ST_RUN: begin
                if (take) begin
                    case (op)
                        SST_OP_SUB_REG: begin
                            next_flags[FLAG_Z] = sub_z;
                            next_flags[FLAG_DC] = sub_dc;
                            next_flags[FLAG_C] = sub_c;
                            if (instr_dest) begin
                                next_freg_we = 1'b1;
                                next_freg_waddr = instr_reg_addr;
                                next_freg_wdata = sub_result;
                            end else begin
                                next_acc = sub_result;
                            end
                        end
                        SST_OP_SUB_IMM: begin
                            next_flags[FLAG_Z] = sub_z;
                            next_flags[FLAG_DC] = sub_dc;
                            next_flags[FLAG_C] = sub_c;
                            next_acc = sub_result;
                        end
                        SST_OP_SWAP: begin
                            if (instr_dest) begin
                                next_freg_we = 1'b1;
                                next_freg_waddr = instr_reg_addr;
                                next_freg_wdata = swap_result;
                            end else begin
                                next_acc = swap_result;
                            end
                        end
                        SST_OP_TABLE: begin
                            next_rom_rd = 1'b1;
                            next_rom_addr = {table_pointer_high, acc};
                            next_instr_stall = 1'b1;
                            next_state = SST_ST_TABLE;
                        end
                        default: begin
                            next_state = SST_ST_RUN;
                        end
                    endcase
                end
            end
            SST_ST_TABLE: begin
                next_acc = rom_data[7:0];
                next_table_data_high = rom_data[13:8];
                next_state = SST_ST_RUN;
            end
            default: begin
                next_state = SST_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= SST_ST_RUN;
            acc <= ACC_RST;
            flags <= FLAGS_RST;
            table_pointer_high <= TPH_RST;
            table_data_high <= TDH_RST;
            instr_stall <= 1'b0;
            freg_we <= 1'b0;
            freg_waddr <= 6'h00;
            freg_wdata <= 8'h00;
            rom_rd <= 1'b0;
            rom_addr <= 11'h000;
        end else begin
            state <= next_state;
            acc <= next_acc;
            flags <= next_flags;
            table_pointer_high <= next_table_pointer_high;
            table_data_high <= next_table_data_high;
            instr_stall <= next_instr_stall;
            freg_we <= next_freg_we;
            freg_waddr <= next_freg_waddr;
            freg_wdata <= next_freg_wdata;
            rom_rd <= next_rom_rd;
            rom_addr <= next_rom_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave, zero wait states

    always_comb begin
        next_wr_pend = addr_phase && hwrite;
        next_wr_addr = addr_phase ? haddr[7:0] : wr_addr;
        next_hrdata = 32'h0000_0000;
        if (addr_phase && !hwrite) begin
            if (haddr[7:0] == OFS_ACC) begin
                next_hrdata = {24'h00_0000, acc};
            end else if (haddr[7:0] == OFS_FLAGS) begin
                next_hrdata = {29'h0000_0000, flags};
            end else if (haddr[7:0] == OFS_TPH) begin
                next_hrdata = {29'h0000_0000, table_pointer_high};
            end else if (haddr[7:0] == OFS_TDH) begin
                next_hrdata = {26'h000_0000, table_data_high};
            end else if (haddr[7:0] == OFS_STATE) begin
                next_hrdata = {31'h0000_0000, instr_stall};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    logic [7:0] chk_reg_diff;
    logic [7:0] chk_imm_diff;
    logic chk_reg_nb;
    logic chk_imm_nb;
    logic chk_flag_wr;

    assign chk_reg_diff = freg_rdata - acc;
    assign chk_imm_diff = instr_imm - acc;
    assign chk_reg_nb = (freg_rdata >= acc);
    assign chk_imm_nb = (instr_imm >= acc);
    assign chk_flag_wr = wr_pend && (wr_addr == OFS_FLAGS);

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_take_sub_reg;
        take && op == SST_OP_SUB_REG;
    endsequence

    sequence s_take_table;
        take && op == SST_OP_TABLE;
    endsequence

    sequence s_table_end;
        instr_stall && state == SST_ST_TABLE ##1 !instr_stall && state == SST_ST_RUN;
    endsequence

    property p_sub_reg_to_acc;
        s_take_sub_reg and (!instr_dest) |=> acc == $past(chk_reg_diff) && !freg_we;
    endproperty
    a_sub_reg_to_acc: assert property (p_sub_reg_to_acc) else $error("reg minus acc not in acc");

    property p_sub_reg_to_reg;
        s_take_sub_reg and instr_dest |=>
            freg_we && freg_wdata == $past(chk_reg_diff) && freg_waddr == $past(instr_reg_addr);
    endproperty
    a_sub_reg_to_reg: assert property (p_sub_reg_to_reg) else $error("reg minus acc not written back");

    property p_sub_carry;
        take && (op == SST_OP_SUB_REG || op == SST_OP_SUB_IMM) |=>
            flags[FLAG_C] == ($past(op) == SST_OP_SUB_IMM ? $past(chk_imm_nb) : $past(chk_reg_nb));
    endproperty
    a_sub_carry: assert property (p_sub_carry) else $error("carry wrong after subtract");

    property p_sub_zero;
        s_take_sub_reg |=> flags[FLAG_Z] == ($past(chk_reg_diff) == 8'h00);
    endproperty
    a_sub_zero: assert property (p_sub_zero) else $error("zero flag wrong after subtract");

    property p_sub_imm;
        take && op == SST_OP_SUB_IMM |=> acc == $past(chk_imm_diff) && !freg_we;
    endproperty
    a_sub_imm: assert property (p_sub_imm) else $error("imm minus acc not in acc");

    property p_swap;
        take && op == SST_OP_SWAP && !chk_flag_wr |=> $stable(flags) &&
            (freg_we ? freg_wdata == {$past(freg_rdata[3:0]), $past(freg_rdata[7:4])}
                     : acc == {$past(freg_rdata[3:0]), $past(freg_rdata[7:4])});
    endproperty
    a_swap: assert property (p_swap) else $error("nibble swap wrong");

    property p_table_addr;
        s_take_table |=> rom_rd && rom_addr == {$past(table_pointer_high), $past(acc)} ##1 !rom_rd;
    endproperty
    a_table_addr: assert property (p_table_addr) else $error("table address wrong");

    property p_table_data;
        s_take_table ##1 1'b1 |=> acc == $past(rom_data[7:0]) && table_data_high == $past(rom_data[13:8]);
    endproperty
    a_table_data: assert property (p_table_data) else $error("table data not loaded");

    property p_table_cycles;
        s_take_table |=> s_table_end;
    endproperty
    a_table_cycles: assert property (p_table_cycles) else $error("table read not two cycles");

    property p_single_cycle;
        take && op != SST_OP_TABLE |=> !instr_stall;
    endproperty
    a_single_cycle: assert property (p_single_cycle) else $error("single cycle op stalled");

endmodule

/* verif/sst_far.sv */
// far side model: file register array and program rom
// assumes the execution slice asks for rom words only with its read strobe high
`timescale 1ns/1ps
module sst_far
    import sst_pkg::*;
(
    input wire logic hclk,
    input wire logic instr_valid,
    input wire logic [5:0] instr_reg_addr,
    input wire logic freg_we,
    input wire logic [5:0] freg_waddr,
    input wire logic [7:0] freg_wdata,
    input wire logic rom_rd,
    input wire logic [10:0] rom_addr,
    output logic [7:0] freg_rdata,
    output logic [13:0] rom_data
);
    logic [7:0] mem [64];
    logic [13:0] rom [2048];
    logic tick = 1'b0;
    ////////////////////////////////////////////////////////////////////////////
    // register file, written on the slice's strobe
    always @(posedge hclk) begin
        tick <= ~tick;
        if (freg_we) begin
            mem[freg_waddr] <= freg_wdata;
        end
    end
    // outside a request the register lines carry the inverted word and the rom lines a changing pattern, not the last value
    // a write still pending from the slice is passed straight through
    assign freg_rdata = !instr_valid ? ~mem[instr_reg_addr] :
        (freg_we && freg_waddr == instr_reg_addr) ? freg_wdata : mem[instr_reg_addr];
    assign rom_data = rom_rd ? rom[rom_addr] : ({7{2'b10}} ^ {14{tick}});
endmodule

/* verif/tb_top.sv */
// testbench for the subtract, swap and table read slice
// assumes the far side model drives file register and rom data
`timescale 1ns/1ps
module tb_top
    import sst_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, instr_stall, freg_we, rom_rd;
    logic [31:0] hrdata;
    logic instr_valid = 1'b0;
    logic [1:0] instr_op = 2'b00;
    logic [5:0] instr_reg_addr = 6'h00;
    logic instr_dest = 1'b0;
    logic [7:0] instr_imm = 8'h00;
    logic [7:0] freg_rdata, freg_wdata, acc;
    logic [5:0] freg_waddr;
    logic [10:0] rom_addr;
    logic [13:0] rom_data;
    logic [2:0] flags;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [10:0] e;

    always #2.5 hclk = ~hclk;

    sst_exec sst_exec_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_reg_addr(instr_reg_addr), .instr_dest(instr_dest), .instr_imm(instr_imm),
        .freg_rdata(freg_rdata), .instr_stall(instr_stall), .freg_we(freg_we), .freg_waddr(freg_waddr),
        .freg_wdata(freg_wdata), .rom_rd(rom_rd), .rom_addr(rom_addr), .rom_data(rom_data), .acc(acc),
        .flags(flags));
    sst_far sst_far_inst (.hclk(hclk), .instr_valid(instr_valid), .instr_reg_addr(instr_reg_addr),
        .freg_we(freg_we), .freg_waddr(freg_waddr), .freg_wdata(freg_wdata), .rom_rd(rom_rd),
        .rom_addr(rom_addr), .freg_rdata(freg_rdata), .rom_data(rom_data));
    ////////////////////////////////////////////////////////////////////////////
    // tasks
    task automatic print_verdict();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic instr(input logic [1:0] op, input logic [5:0] ra, input logic d, input logic [7:0] im);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_reg_addr <= ra;
        instr_dest <= d;
        instr_imm <= im;
        @(posedge hclk);
        instr_valid <= 1'b0;
        #1;
    endtask

    // zero, no borrow from low nibble, no borrow overall, difference
    function automatic logic [10:0] sub_ref(input logic [7:0] r, input logic [7:0] a);
        logic [7:0] s;
        s = r - a;
        return {s == 8'h00, r[3:0] >= a[3:0], r >= a, s};
    endfunction

    // one subtract: operand r, accumulator a
    task automatic run_sub(input logic [1:0] op, input logic [5:0] ra, input logic d,
        input logic [7:0] r, input logic [7:0] a);
        sst_far_inst.mem[ra] = r;
        bus(OFS_ACC, 1'b1, {24'h0, a});
        e = sub_ref(r, a);
        instr(op, ra, d, r);
        check(flags, e[10:8]);
        if (op == SST_OP_SUB_REG && d) begin
            check({freg_we, freg_waddr, freg_wdata}, {1'b1, ra, e[7:0]});
            check(acc, a);
        end else begin
            check(acc, e[7:0]);
            check(freg_we, 1'b0);
        end
        @(posedge hclk);
        #1;
        check(freg_we, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // timeout
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(OFS_ACC, 1'b0, 32'h0);
        check(rd, {24'h0, ACC_RST});
        check({hreadyout, hresp}, 2'b10);
        bus(OFS_FLAGS, 1'b0, 32'h0);
        check(rd, {29'h0, FLAGS_RST});
        bus(OFS_TDH, 1'b0, 32'h0);
        check(rd, {26'h0, TDH_RST});
        bus(8'h20, 1'b1, 32'hffffffff);
        bus(8'h20, 1'b0, 32'h0);
        check(rd, 32'h0);
        run_sub(SST_OP_SUB_REG, 6'd5, 1'b1, 8'h05, 8'h06);
        run_sub(SST_OP_SUB_REG, 6'd63, 1'b0, 8'h06, 8'h05);
        run_sub(SST_OP_SUB_REG, 6'd0, 1'b1, 8'h80, 8'h80);
        run_sub(SST_OP_SUB_IMM, 6'd1, 1'b0, 8'h05, 8'h05);
        run_sub(SST_OP_SUB_IMM, 6'd2, 1'b1, 8'h30, 8'hf1);
        // swap keeps flags, both destinations
        bus(OFS_FLAGS, 1'b1, 32'h5);
        sst_far_inst.mem[9] = 8'ha5;
        instr(SST_OP_SWAP, 6'd9, 1'b1, 8'h00);
        check({freg_we, freg_waddr, freg_wdata}, {1'b1, 6'd9, 8'h5a});
        check(flags, 3'h5);
        instr(SST_OP_SWAP, 6'd9, 1'b0, 8'h00);
        check(acc, 8'ha5);
        check(flags, 3'h5);
        // table read across pointer and accumulator
        sst_far_inst.rom[11'h234] = 14'h35aa;
        bus(OFS_TPH, 1'b1, 32'h2);
        bus(OFS_ACC, 1'b1, 32'h34);
        instr(SST_OP_TABLE, 6'd0, 1'b0, 8'h00);
        check({rom_rd, rom_addr}, {1'b1, 11'h234});
        check(instr_stall, 1'b1);
        @(posedge hclk);
        #1;
        check(acc, 8'haa);
        check({instr_stall, rom_rd}, 2'b00);
        bus(OFS_TDH, 1'b0, 32'h0);
        check(rd, 32'h35);
        // stall readable in the table read's second cycle
        sst_far_inst.rom[11'h2aa] = 14'h0123;
        instr(SST_OP_TABLE, 6'd0, 1'b0, 8'h00);
        bus(OFS_STATE, 1'b0, 32'h0);
        check(rd, 32'h1);
        check(acc, 8'h23);
        bus(OFS_TDH, 1'b0, 32'h0);
        check(rd, 32'h01);
        print_verdict();
    end
endmodule
